// *** shared/rurc_pkg.sv ***
// Constants for the remote upgrade register chain.
// Assumes a single 10 MHz system clock; control fields sit in one 40-bit word.
package rurc_pkg;
  localparam int ADDR_W = 24;
  localparam int CTRL_W = 40;
  localparam int STAT_W = 5;
  // Control word layout
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_WD_VAL_LSB = 24;
  localparam int CTRL_WD_VAL_W = 12;
  localparam int CTRL_WD_EN_BIT = 36;
  localparam int CTRL_EARLY_DONE_BIT = 37;
  localparam int CTRL_OSC_SEL_BIT = 38;
  localparam int CTRL_SPARE_BIT = 39;
  // Power-up addresses
  localparam logic [23:0] SERIAL_BOOT_ADDR = 24'h000000;
  localparam logic [23:0] PARALLEL_BOOT_ADDR = 24'h010000;
  // Status cause bits
  localparam int STAT_CRC_BIT = 0;
  localparam int STAT_STATUS_BIT = 1;
  localparam int STAT_CORE_BIT = 2;
  localparam int STAT_PIN_BIT = 3;
  localparam int STAT_WD_BIT = 4;
  // Shift clock ceiling
  localparam int SHIFT_CLK_MAX_MHZ = 40;
  localparam int SYS_CLK_MHZ = 10;
  // Operation codes from fabric
  typedef enum logic [1:0] {
    RURC_OP_IDLE = 2'h0,
    RURC_OP_READ = 2'h1,
    RURC_OP_CAPTURE = 2'h2,
    RURC_OP_UPDATE = 2'h3
  } rurc_op_t;
endpackage

// *** logic/rurc_chain.sv ***
// Remote upgrade register chain: shift, update, control and status words.
// Assumes fabric drives op and serial data synchronous to ref_clk, which
// stands in for the upgrade shift clock; the oscillator domain is merged.
`timescale 1ns/1ps
// Behaviour
// - Fabric writes update and control words and samples update, status and control words through the shift word.
// - A factory image in remote mode may write through the shift word to load the update word.
// - An application image in remote mode cannot write through the shift word.
// - The control word holds boot address, watchdog settings, early-done and oscillator bits.
// - A read under an application image loads the control word into the shift word.
// - At the start of reconfiguration the update word is copied into the control word.
// - The update word changes only on an update issued by a factory image after shifting.
// - A read under a factory image loads the update word into the shift word.
// - Each reconfiguration records its cause in the status word.
// - A capture loads the status word into the shift word.
// - Control and status words run on the oscillator or the user clock pin.
// - Shift and update words run on the shift clock, kept at or under 40 MHz by fabric.
// - Serial flash boot clears the 24 address bits at power up.
// - Parallel flash boot presets the address to the default factory location.
// - The parallel default factory address can be replaced by a scan instruction.
// - A factory image in remote mode may write the control word.
module rurc_chain (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic remote_mode,
  input wire logic factory_image,
  input wire logic parallel_flash_boot_scheme,
  input wire logic parallel_factory_address_instr,
  input wire logic [23:0] scan_factory_addr,
  input wire logic shift_en,
  input wire logic shift_in,
  input wire logic [1:0] op,
  input wire logic ctrl_write,
  input wire logic reconfig_start,
  input wire logic [4:0] reconfig_cause,
  output logic shift_out,
  output logic [39:0] shift_word,
  output logic [39:0] update_word,
  output logic [39:0] ctrl_word,
  output logic [4:0] status_word,
  output logic [23:0] boot_addr,
  output logic watchdog_en,
  output logic [11:0] watchdog_val,
  output logic early_done_check,
  output logic osc_startup_clk,
  output logic write_allowed
);
  // Live words of the chain
  logic [39:0] shift_reg;
  logic [39:0] shift_next;
  logic [39:0] update_reg;
  logic [39:0] update_next;
  logic [39:0] ctrl_reg;
  logic [39:0] ctrl_next;
  logic [4:0] status_reg;
  logic [4:0] status_next;
  // Parallel boot default, retargeted by the scan instruction
  logic [23:0] factory_addr_reg;
  logic [23:0] factory_addr_next;
  // Low only up to the first edge after reset
  logic powered_reg;
  logic powered_next;
  // Parallel sources
  logic [39:0] default_ctrl;
  logic [39:0] read_source;
  logic [39:0] capture_word;
  // Decoded operation
  rurc_pkg::rurc_op_t op_code;
  logic idle_op;
  logic read_op;
  logic capture_op;
  logic update_op;
  // Qualified load strobes
  logic shift_step;
  logic update_load;
  logic ctrl_load;
  logic reconfig_load;
  logic power_up_load;
  // Serial input seen by each bit
  logic [39:0] serial_src;

  // Writes only from a factory image in remote mode; reads stay open
  assign write_allowed = remote_mode & factory_image;

  // Every code of the two-bit field is defined, so no default arm
  assign op_code = rurc_pkg::rurc_op_t'(op);

  always_comb begin
    idle_op = 1'h0;
    read_op = 1'h0;
    capture_op = 1'h0;
    update_op = 1'h0;
    unique case (op_code)
      rurc_pkg::RURC_OP_IDLE: begin
        idle_op = 1'h1;
      end
      rurc_pkg::RURC_OP_READ: begin
        read_op = 1'h1;
      end
      rurc_pkg::RURC_OP_CAPTURE: begin
        capture_op = 1'h1;
      end
      rurc_pkg::RURC_OP_UPDATE: begin
        update_op = 1'h1;
      end
    endcase
  end

  // Shift, update and control-write strobes gated by the write rights; reconfig and power-up loads are not
  assign shift_step = shift_en & write_allowed & (idle_op | update_op);
  assign update_load = update_op & write_allowed;
  assign ctrl_load = ctrl_write & write_allowed;
  assign reconfig_load = reconfig_start;
  assign power_up_load = ~powered_reg;

  // Image type picks which word a read returns
  always_comb begin
    if (factory_image) begin
      read_source = update_reg;
    end else begin
      read_source = ctrl_reg;
    end
  end

  // Status sits in the low bits; upper bits read back as zero
  always_comb begin
    capture_word = '0;
    capture_word[rurc_pkg::STAT_W-1:0] = status_reg;
  end

  // Scan instruction retargets the parallel factory address
  always_comb begin
    if (parallel_factory_address_instr) begin
      factory_addr_next = scan_factory_addr;
    end else begin
      factory_addr_next = factory_addr_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      factory_addr_reg <= rurc_pkg::PARALLEL_BOOT_ADDR;
    end else begin
      factory_addr_reg <= factory_addr_next;
    end
  end

  // Power-up word; an instruction in the power-up cycle is honoured at once,
  // since it takes factory_addr_next rather than the address stored at reset
  always_comb begin
    default_ctrl = '0;
    if (parallel_flash_boot_scheme) begin
      default_ctrl[rurc_pkg::CTRL_ADDR_LSB +: rurc_pkg::ADDR_W] =
        factory_addr_next;
    end else begin
      default_ctrl[rurc_pkg::CTRL_ADDR_LSB +: rurc_pkg::ADDR_W] =
        rurc_pkg::SERIAL_BOOT_ADDR;
    end
  end

  // Each bit takes its upper neighbour; the top bit takes the serial pin
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < rurc_pkg::CTRL_W; bit_idx = bit_idx + 1) begin : g_shift_bit
      if (bit_idx == rurc_pkg::CTRL_W - 1) begin : g_top
        assign serial_src[bit_idx] = shift_in;
      end else begin : g_inner
        assign serial_src[bit_idx] = shift_reg[bit_idx + 1];
      end
      // Capture beats read beats shift
      assign shift_next[bit_idx] = capture_op ? capture_word[bit_idx] :
                                   read_op ? read_source[bit_idx] :
                                   shift_step ? serial_src[bit_idx] :
                                   shift_reg[bit_idx];
    end
  endgenerate

  // Shift and update words belong to the shift clock, merged into ref_clk
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // Only a factory update moves this word
  always_comb begin
    if (update_load) begin
      update_next = shift_reg;
    end else begin
      update_next = update_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      update_reg <= '0;
    end else begin
      update_reg <= update_next;
    end
  end

  assign powered_next = 1'h1;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      powered_reg <= 1'h0;
    end else begin
      powered_reg <= powered_next;
    end
  end

  // Reconfiguration beats a direct write, since it reboots the device anyway
  always_comb begin
    if (power_up_load) begin
      ctrl_next = default_ctrl;
    end else if (reconfig_load) begin
      ctrl_next = update_reg;
    end else if (ctrl_load) begin
      ctrl_next = shift_reg;
    end else begin
      ctrl_next = ctrl_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_comb begin
    if (reconfig_load) begin
      status_next = reconfig_cause;
    end else begin
      status_next = status_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign shift_out = shift_reg[0];
  assign shift_word = shift_reg;
  assign update_word = update_reg;
  assign ctrl_word = ctrl_reg;
  assign status_word = status_reg;
  // Control word fields
  assign boot_addr = ctrl_reg[rurc_pkg::CTRL_ADDR_LSB +: rurc_pkg::ADDR_W];
  assign watchdog_val = ctrl_reg[rurc_pkg::CTRL_WD_VAL_LSB +: rurc_pkg::CTRL_WD_VAL_W];
  assign watchdog_en = ctrl_reg[rurc_pkg::CTRL_WD_EN_BIT];
  assign early_done_check = ctrl_reg[rurc_pkg::CTRL_EARLY_DONE_BIT];
  assign osc_startup_clk = ctrl_reg[rurc_pkg::CTRL_OSC_SEL_BIT];
endmodule

// *** bench/rurc_chain_assertions.sv ***
// Port checker for the register chain.
// Assumes bind to rurc_chain; one clock, sync reset.
`timescale 1ns/1ps
module rurc_chain_assertions (
  input wire logic ref_clk, rstn, remote_mode, factory_image, shift_en, shift_in,
  input wire logic ctrl_write, reconfig_start, write_allowed,
  input wire logic [1:0] op,
  input wire logic [4:0] reconfig_cause, status_word,
  input wire logic [39:0] shift_word, update_word, ctrl_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_upd; op == 2'h3 && write_allowed; endsequence
  a_gate_comb: assert property (write_allowed == (remote_mode && factory_image))
    else $error("write gate wrong");
  a_update_load: assert property (s_upd |=> update_word == $past(shift_word))
    else $error("update not loaded");
  a_update_hold: assert property (!(op == 2'h3 && write_allowed) |=> $stable(update_word))
    else $error("update moved");
  a_read_fact: assert property (op == 2'h1 && factory_image
    |=> shift_word == $past(update_word)) else $error("factory read wrong");
  a_read_app: assert property (op == 2'h1 && !factory_image
    |=> shift_word == $past(ctrl_word)) else $error("app read wrong");
  a_capture_stat: assert property (op == 2'h2 |=> shift_word == {35'h0, $past(status_word)})
    else $error("capture wrong");
  a_reconfig_copy: assert property (reconfig_start |=> ctrl_word == $past(update_word)
    && status_word == $past(reconfig_cause)) else $error("reconfig wrong");
  a_ctrl_write: assert property (ctrl_write && write_allowed && !reconfig_start
    |=> ctrl_word == $past(shift_word)) else $error("ctrl write wrong");
  a_shift_step: assert property (shift_en && op == 2'h0 |=> shift_word ==
    (write_allowed ? {$past(shift_in), $past(shift_word[39:1])} : $past(shift_word)))
    else $error("shift wrong");
endmodule

// *** bench/rurc_fabric.sv ***
// Fabric-side model of the serial chain user.
// Assumes tasks are entered just after a rising ref_clk edge.
`timescale 1ns/1ps
module rurc_fabric (
  input wire logic ref_clk,
  output logic shift_en = 1'b0,
  output logic shift_in = 1'b0,
  output logic ctrl_write = 1'b0,
  output logic [1:0] op = 2'h0
);
  task automatic send40(input logic [39:0] v);
    for (int i = 0; i < 40; i++) begin
      shift_en = 1'h1;
      shift_in = v[i];
      @(posedge ref_clk) #1;
    end
    shift_en = 1'b0;
    shift_in = ~shift_in; // Released line must not look valid
  endtask
  task automatic pulse(input logic [1:0] code, input logic wr);
    op = code;
    ctrl_write = wr;
    @(posedge ref_clk) #1;
    op = 2'h0;
    ctrl_write = 1'b0;
  endtask
endmodule

// *** bench/tb_rurc_chain.sv ***
// Self-checking bench for the register chain.
// Assumes the fabric model drives the serial side.
`timescale 1ns/1ps
module tb_rurc_chain;
  logic ref_clk = 1'b0, rstn = 1'b0, remote_mode = 1'b1, factory_image = 1'b1;
  logic parallel_flash_boot_scheme = 1'h1, reconfig_start = 1'h0;
  logic parallel_factory_address_instr = 1'h0;
  logic [23:0] scan_factory_addr = 24'h2A5C3E;
  logic watchdog_en, early_done_check, osc_startup_clk;
  logic [11:0] watchdog_val;
  logic shift_en, shift_in, ctrl_write, shift_out, write_allowed;
  logic [1:0] op;
  logic [4:0] status_word, reconfig_cause = 5'h00;
  logic [39:0] shift_word, update_word, ctrl_word;
  logic [23:0] boot_addr;
  int failures = 0, total_checks = 0;
  initial forever #50 ref_clk = ~ref_clk;
  rurc_fabric rurc_fabric_inst (.*);
  rurc_chain rurc_chain_inst (.*);
  task automatic chk(input logic [39:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset(input logic par, input logic scan);
    parallel_flash_boot_scheme = par;
    rstn = 1'h0;
    repeat (16) @(posedge ref_clk);
    #1 rstn = 1'h1;
    parallel_factory_address_instr = scan;
    @(posedge ref_clk) #1 parallel_factory_address_instr = 1'h0;
    @(posedge ref_clk) #1;
  endtask
  initial begin
    do_reset(1'h1, 1'h0);
    chk(boot_addr, 24'h010000);
    do_reset(1'h1, 1'h1);
    chk(boot_addr, 24'h2A5C3E);
    do_reset(1'h0, 1'h0);
    chk(boot_addr, 24'h000000);
    rurc_fabric_inst.send40(40'hA512345679);
    chk(shift_out, 1'h1);
    chk(shift_word, 40'hA512345679);
    rurc_fabric_inst.pulse(2'h3, 1'h0);
    chk(update_word, 40'hA512345679);
    rurc_fabric_inst.pulse(2'h2, 1'h0);
    chk(shift_word, 40'h0000000000);
    rurc_fabric_inst.pulse(2'h1, 1'h0);
    chk(shift_word, 40'hA512345679);
    reconfig_start = 1'h1;
    for (int i = 0; i < 5; i++) begin
      reconfig_cause = 5'h01 << i;
      @(posedge ref_clk) #1;
      chk(status_word, 5'h01 << i);
    end
    reconfig_start = 1'h0;
    chk(ctrl_word, 40'hA512345679);
    chk(boot_addr, 24'h345679);
    chk(watchdog_val, 12'h512);
    chk(watchdog_en, 1'h0);
    chk(early_done_check, 1'h1);
    chk(osc_startup_clk, 1'h0);
    rurc_fabric_inst.pulse(2'h2, 1'h0);
    chk(shift_word, 40'h0000000010);
    rurc_fabric_inst.send40(40'h5C0F00FF01);
    rurc_fabric_inst.pulse(2'h0, 1'h1);
    chk(ctrl_word, 40'h5C0F00FF01);
    chk(watchdog_val, 12'hC0F);
    chk(watchdog_en, 1'h1);
    chk(early_done_check, 1'h0);
    chk(osc_startup_clk, 1'h1);
    factory_image = 1'h0;
    rurc_fabric_inst.send40(40'h0123456789);
    chk(write_allowed, 1'h0);
    chk(shift_word, 40'h5C0F00FF01);
    rurc_fabric_inst.pulse(2'h3, 1'h1);
    chk(update_word, 40'hA512345679);
    chk(ctrl_word, 40'h5C0F00FF01);
    rurc_fabric_inst.pulse(2'h2, 1'h0);
    chk(shift_word, 40'h0000000010);
    rurc_fabric_inst.pulse(2'h1, 1'h0);
    chk(shift_word, 40'h5C0F00FF01);
    final_report();
  end
  initial begin
    #400000;
    failures++;
    final_report();
  end
endmodule
bind rurc_chain rurc_chain_assertions rurc_chain_assertions_inst (.*);
